/* File: rtl/ffsb_cfg.svh */
// fault flag status bank: offsets, reset values and field positions
`ifndef FFSB_CFG_SVH
`define FFSB_CFG_SVH

// word indices; byte address is four times the index
`define FFSB_IDX_FS4      16'hFEC3
`define FFSB_IDX_FS5      16'hFEC4
`define FFSB_IDX_ST4      16'hFEC8
`define FFSB_IDX_ST5      16'hFEC9
`define FFSB_IDX_CAUSE_A  16'hFECA
`define FFSB_IDX_CAUSE_B  16'hFECB
`define FFSB_IDX_IRQ_STAT 16'hFF00
`define FFSB_IDX_IRQ_MASK 16'hFF01
`define FFSB_IDX_SHUT_EN  16'hFF02
`define FFSB_IDX_LL_THR   16'hFF03
`define FFSB_IDX_REV_THR  16'hFF04

// reset values
`define FFSB_RST_FLAGS    8'h00
`define FFSB_RST_CAUSE    8'h00
`define FFSB_RST_IRQ      4'h0
`define FFSB_RST_SHUT_EN  15'h7FFF
`define FFSB_RST_THR      12'h000

// field positions
`define FFSB_FS4_CHAN_C_OFF 6
`define FFSB_FS4_FLAG_PIN   5
`define FFSB_CAUSE_CUR_LSB  0
`define FFSB_CAUSE_PRV_LSB  4
`define FFSB_THR_B_LSB      16
`define FFSB_EN_B_LSB       16
`define FFSB_FAULT_CNT      15

`endif

/* File: rtl/ffsb_pkg.sv */
// fault flag status bank: shared types
package ffsb_pkg;

    // core-side fault levels, codes 12 down to 1 from top to bottom
    typedef struct packed {
        logic zone2_overtemp;
        logic zone1_overtemp;
        logic input_line_sense_low;
        logic main_overcurrent;
        logic chan_b_undervoltage;
        logic chan_a_undervoltage;
        logic chan_b_overvoltage;
        logic chan_a_overvoltage;
        logic chan_b_secondary_overcurrent;
        logic chan_a_secondary_overcurrent;
        logic chan_b_primary_overcurrent;
        logic chan_a_primary_overcurrent;
    } ffsb_faults_t;

    // core-side status levels
    typedef struct packed {
        logic nvm_unlocked;
        logic chan_b_ramp_filter_active;
        logic chan_a_ramp_filter_active;
        logic chan_b_filter_saturated;
        logic chan_a_filter_saturated;
        logic zone2_temp_warning;
        logic zone1_temp_warning;
    } ffsb_status_t;

    typedef enum logic [0:0] {
        FFSB_CH_RUN  = 1'b0,
        FFSB_CH_DOWN = 1'b1
    } ffsb_chan_state_t;

endpackage

/* File: rtl/ffsb_bank.sv */
// fault flag status bank with wishbone register access
`timescale 1ns/1ps
`include "ffsb_cfg.svh"

module ffsb_bank
    import ffsb_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [17:0]  wb_adr_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic         wb_we_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire ffsb_faults_t faults_i,
    input  wire ffsb_status_t status_i,
    input  wire logic [11:0]  chan_a_secondary_current_input_i,
    input  wire logic [11:0]  chan_b_secondary_current_input_i,
    input  wire logic         chan_c_off_i,
    input  wire logic         chan_c_turn_on_input_i,
    input  wire logic         external_flag_input_i,
    input  wire logic [1:0]   chan_restart_i,
    output logic              flag_sync_output_pin_o,
    output logic [1:0]        chan_shutdown_o,
    output logic              irq_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // only the second stage is read; the first may still be settling
    logic       turn_on_meta_ff;
    logic       turn_on_sync_ff;
    logic       ext_flag_meta_ff;
    logic       ext_flag_sync_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            turn_on_meta_ff  <= 1'b0;
            turn_on_sync_ff  <= 1'b0;
            ext_flag_meta_ff <= 1'b0;
            ext_flag_sync_ff <= 1'b0;
        end else if (ce_i) begin
            turn_on_meta_ff  <= chan_c_turn_on_input_i;
            turn_on_sync_ff  <= turn_on_meta_ff;
            ext_flag_meta_ff <= external_flag_input_i;
            ext_flag_sync_ff <= ext_flag_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // bus decode and software registers
    // ------------------------------------------------------------
    logic [15:0] wb_idx;
    logic        wb_req;
    logic        wb_wr;
    logic        wb_wr_lo;
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_mask_ff;
    logic [3:0]  irq_event;
    logic [29:0] shut_en_ff;
    logic [23:0] ll_thr_ff;
    logic [23:0] rev_thr_ff;
    logic        ack_ff;

    assign wb_idx   = wb_adr_i[17:2];
    assign wb_req   = wb_cyc_i && wb_stb_i && !ack_ff;
    // a write takes effect only at the edge that raises ack
    assign wb_wr    = wb_req && wb_we_i && ce_i;
    assign wb_wr_lo = wb_wr && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= `FFSB_RST_IRQ;
            shut_en_ff  <= {`FFSB_RST_SHUT_EN, `FFSB_RST_SHUT_EN};
            ll_thr_ff   <= {`FFSB_RST_THR, `FFSB_RST_THR};
            rev_thr_ff  <= {`FFSB_RST_THR, `FFSB_RST_THR};
        end else if (wb_wr) begin
            case (wb_idx)
                `FFSB_IDX_IRQ_MASK: begin
                    if (wb_sel_i[0]) irq_mask_ff <= wb_dat_i[3:0];
                end
                `FFSB_IDX_SHUT_EN: begin
                    if (&wb_sel_i) shut_en_ff <= {wb_dat_i[30:16], wb_dat_i[14:0]};
                end
                `FFSB_IDX_LL_THR: begin
                    if (&wb_sel_i) ll_thr_ff <= {wb_dat_i[27:16], wb_dat_i[11:0]};
                end
                `FFSB_IDX_REV_THR: begin
                    if (&wb_sel_i) rev_thr_ff <= {wb_dat_i[27:16], wb_dat_i[11:0]};
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // live flags
    // ------------------------------------------------------------
    logic       low_load_a;
    logic       low_load_b;
    logic       rev_a;
    logic       rev_b;
    logic       chan_c_off_ff;
    logic       flag_pin_ff;
    logic [7:0] fault_status_four_ff;
    logic [7:0] fault_status_five_ff;
    logic [7:0] nxt_fs4;
    logic [7:0] nxt_fs5;

    // currents are signed so a reverse threshold can sit below zero
    assign low_load_a = $signed(chan_a_secondary_current_input_i) < $signed(ll_thr_ff[11:0]);
    assign low_load_b = $signed(chan_b_secondary_current_input_i) < $signed(ll_thr_ff[23:12]);
    assign rev_a      = $signed(chan_a_secondary_current_input_i) < $signed(rev_thr_ff[11:0]);
    assign rev_b      = $signed(chan_b_secondary_current_input_i) < $signed(rev_thr_ff[23:12]);

    // set wins over the turn-on clear so an off event is never lost to a simultaneous turn-on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_c_off_ff <= 1'b0;
        end else if (ce_i) begin
            if (chan_c_off_i) begin
                chan_c_off_ff <= 1'b1;
            end else if (turn_on_sync_ff) begin
                chan_c_off_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_pin_ff <= 1'b0;
        end else if (ce_i) begin
            flag_pin_ff <= low_load_a || low_load_b;
        end
    end

    always_comb begin
        nxt_fs4    = `FFSB_RST_FLAGS;
        nxt_fs4[`FFSB_FS4_CHAN_C_OFF] = chan_c_off_ff;
        nxt_fs4[`FFSB_FS4_FLAG_PIN]   = flag_pin_ff;
        nxt_fs4[4] = status_i.nvm_unlocked;
        nxt_fs4[3] = status_i.chan_b_ramp_filter_active;
        nxt_fs4[2] = status_i.chan_a_ramp_filter_active;
        nxt_fs4[1] = status_i.chan_b_filter_saturated;
        nxt_fs4[0] = status_i.chan_a_filter_saturated;
        nxt_fs5    = `FFSB_RST_FLAGS;
        nxt_fs5[3] = status_i.zone2_temp_warning;
        nxt_fs5[2] = status_i.zone1_temp_warning;
        nxt_fs5[1] = rev_b;
        nxt_fs5[0] = rev_a;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_status_four_ff <= `FFSB_RST_FLAGS;
            fault_status_five_ff <= `FFSB_RST_FLAGS;
        end else if (ce_i) begin
            fault_status_four_ff <= nxt_fs4;
            fault_status_five_ff <= nxt_fs5;
        end
    end

    // ------------------------------------------------------------
    // sticky copies, write one to clear
    // ------------------------------------------------------------
    logic [7:0] sticky_four_ff;
    logic [7:0] sticky_five_ff;
    logic [7:0] clr4;
    logic [7:0] clr5;

    assign clr4 = (wb_wr_lo && wb_idx == `FFSB_IDX_ST4) ? wb_dat_i[7:0] : 8'h00;
    assign clr5 = (wb_wr_lo && wb_idx == `FFSB_IDX_ST5) ? wb_dat_i[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_four_ff <= `FFSB_RST_FLAGS;
            sticky_five_ff <= `FFSB_RST_FLAGS;
        end else if (ce_i) begin
            sticky_four_ff <= (sticky_four_ff & ~clr4) | fault_status_four_ff;
            sticky_five_ff <= (sticky_five_ff & ~clr5) | fault_status_five_ff;
        end
    end

    // ------------------------------------------------------------
    // shutdown cause recording
    // ------------------------------------------------------------
    logic [14:0]      fault_vec;
    logic [14:0]      cand      [2];
    logic [7:0]       cause_ff  [2];
    ffsb_chan_state_t chan_st_ff[2];
    logic [1:0]       recorded;

    // bit i carries fault code i+1
    assign fault_vec = {rev_b, rev_a, ext_flag_sync_ff, faults_i};

    // lowest code wins when several faults appear in one cycle
    function automatic logic [3:0] pick_code(input logic [14:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 14; i >= 0; i--) begin
            if (v[i]) r = 4'(i + 1);
        end
        return r;
    endfunction

    // enables are per channel, so one fault may stop A and leave B running
    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign cand[c]     = fault_vec & shut_en_ff[c*15 +: 15];
        assign recorded[c] = ce_i && chan_st_ff[c] == FFSB_CH_RUN && |cand[c];

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                chan_st_ff[c] <= FFSB_CH_RUN;
                cause_ff[c]   <= `FFSB_RST_CAUSE;
            end else if (ce_i) begin
                case (chan_st_ff[c])
                    FFSB_CH_RUN: begin
                        if (|cand[c]) begin
                            cause_ff[c]   <= {cause_ff[c][3:0], pick_code(cand[c])};
                            chan_st_ff[c] <= FFSB_CH_DOWN;
                        end
                    end
                    FFSB_CH_DOWN: begin
                        // a restart while an enabled fault is still present is refused
                        if (chan_restart_i[c] && !(|cand[c])) chan_st_ff[c] <= FFSB_CH_RUN;
                    end
                    default: chan_st_ff[c] <= FFSB_CH_RUN;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_shutdown_o        <= 2'b00;
            flag_sync_output_pin_o <= 1'b0;
        end else if (ce_i) begin
            chan_shutdown_o        <= {chan_st_ff[1] == FFSB_CH_DOWN, chan_st_ff[0] == FFSB_CH_DOWN};
            flag_sync_output_pin_o <= flag_pin_ff;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [3:0] irq_clr;

    // events that land while masked stay pending and show once unmasked
    assign irq_event = {ce_i && low_load_a | low_load_b && !flag_pin_ff,
                        ce_i && chan_c_off_i && !chan_c_off_ff,
                        recorded[1], recorded[0]};
    assign irq_clr   = (wb_wr_lo && wb_idx == `FFSB_IDX_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= `FFSB_RST_IRQ;
            irq_o       <= 1'b0;
        end else if (ce_i) begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_event;
            irq_o       <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------
    logic [31:0] nxt_rd;

    always_comb begin
        nxt_rd = 32'h0000_0000;
        case (wb_idx)
            `FFSB_IDX_FS4:      nxt_rd[7:0]   = fault_status_four_ff;
            `FFSB_IDX_FS5:      nxt_rd[7:0]   = fault_status_five_ff;
            `FFSB_IDX_ST4:      nxt_rd[7:0]   = sticky_four_ff;
            `FFSB_IDX_ST5:      nxt_rd[7:0]   = sticky_five_ff;
            `FFSB_IDX_CAUSE_A:  nxt_rd[7:0]   = cause_ff[0];
            `FFSB_IDX_CAUSE_B:  nxt_rd[7:0]   = cause_ff[1];
            `FFSB_IDX_IRQ_STAT: nxt_rd[3:0]   = irq_stat_ff;
            `FFSB_IDX_IRQ_MASK: nxt_rd[3:0]   = irq_mask_ff;
            `FFSB_IDX_SHUT_EN:  nxt_rd        = {1'b0, shut_en_ff[29:15], 1'b0, shut_en_ff[14:0]};
            `FFSB_IDX_LL_THR:   nxt_rd        = {4'h0, ll_thr_ff[23:12], 4'h0, ll_thr_ff[11:0]};
            `FFSB_IDX_REV_THR:  nxt_rd        = {4'h0, rev_thr_ff[23:12], 4'h0, rev_thr_ff[11:0]};
            default:            nxt_rd        = 32'h0000_0000;
        endcase
    end

    // unmapped addresses still ack, reading zero, so a stray access never hangs the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff   <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_ff   <= wb_req;
            wb_dat_o <= wb_req ? nxt_rd : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_chan_c_hold: assert property (chan_c_off_ff && !turn_on_sync_ff |=> chan_c_off_ff)
        else $error("channel C off bit dropped without turn-on");
    a_chan_c_read: assert property (ce_i && chan_c_off_i ##1 ce_i |=> fault_status_four_ff[6])
        else $error("channel C off not shown in status");
    a_flag_pin_ll: assert property (ce_i && low_load_b ##1 ce_i |=> fault_status_four_ff[5])
        else $error("flag pin bit missing on low load");
    a_sticky_keep: assert property (ce_i && clr4 == 8'h00 |=> (sticky_four_ff & $past(sticky_four_ff)) == $past(sticky_four_ff))
        else $error("sticky bit lost without clear");
    a_reserved_zero: assert property (fault_status_four_ff[7] == 1'b0 && sticky_five_ff[7:4] == 4'h0)
        else $error("reserved bit set");
    a_cause_shift: assert property (recorded[0] |=> cause_ff[0][7:4] == $past(cause_ff[0][3:0]))
        else $error("previous cause not shifted");
    // the new code indexes the sampled candidates of the recording cycle
    a_cause_valid: assert property (recorded[1] |=> cause_ff[1][3:0] != 4'h0 && ($past(cand[1]) & (15'h0001 << (cause_ff[1][3:0] - 4'h1))) != 15'h0000)
        else $error("recorded cause not an active fault");
    a_cause_lowest: assert property (recorded[0] |=> ($past(cand[0]) & ((15'h0001 << (cause_ff[0][3:0] - 4'h1)) - 15'h0001)) == 15'h0000)
        else $error("recorded cause not the lowest active code");
    a_cause_frozen: assert property (chan_st_ff[0] == FFSB_CH_DOWN |=> $stable(cause_ff[0]))
        else $error("cause changed while channel down");
    a_cause_frozen_b: assert property (chan_st_ff[1] == FFSB_CH_DOWN |=> $stable(cause_ff[1]))
        else $error("channel B cause changed while down");
    a_rev_flag: assert property (ce_i && rev_a ##1 ce_i |-> fault_status_five_ff[0])
        else $error("reverse current flag missing");
    a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_sticky_set: assert property (ce_i && fault_status_five_ff[0] |=> sticky_five_ff[0])
        else $error("sticky bit not set by live flag");
    a_flag_out: assert property (ce_i && flag_pin_ff |=> flag_sync_output_pin_o)
        else $error("flag output pin not driven on low load");
    a_shut_out: assert property (ce_i && chan_st_ff[1] == FFSB_CH_DOWN |=> chan_shutdown_o[1])
        else $error("shutdown output missing while channel down");
    a_irq_masked: assert property (ce_i && irq_mask_ff == 4'h0 |=> !irq_o)
        else $error("interrupt raised while fully masked");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_chan_c_cycle: cover property (chan_c_off_ff ##[1:20] !chan_c_off_ff);
    c_cause_twice: cover property (recorded[0] && cause_ff[0][3:0] != 4'h0);
    c_irq_raise: cover property (!irq_o ##1 irq_o);
    c_ext_flag_cause: cover property (recorded[0] && cand[0][12]);
    c_rev_b_cause: cover property (recorded[1] && cand[1][14]);

endmodule // ffsb_bank

/* File: testbench/ffsb_bank_tb.sv */
// self-checking bench for the fault flag status bank
`timescale 1ns/1ps
`include "ffsb_cfg.svh"

module ffsb_bank_tb
    import ffsb_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic         clk_i;
    logic         rst_i;
    logic         ce_i;
    logic [17:0]  wb_adr_i;
    logic [31:0]  wb_dat_i;
    logic [3:0]   wb_sel_i;
    logic         wb_we_i;
    logic         wb_cyc_i;
    logic         wb_stb_i;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    ffsb_faults_t faults_i;
    ffsb_status_t status_i;
    logic [11:0]  chan_a_secondary_current_input_i;
    logic [11:0]  chan_b_secondary_current_input_i;
    logic         chan_c_off_i;
    logic         chan_c_turn_on_input_i;
    logic         external_flag_input_i;
    logic [1:0]   chan_restart_i;
    logic         flag_sync_output_pin_o;
    logic [1:0]   chan_shutdown_o;
    logic         irq_o;
    logic [31:0]  d;
    int           fail_count;
    int           comparisons;

    typedef struct packed {
        logic [6:0]  st;
        logic [15:0] idx;
        logic [7:0]  exp;
    } ffsb_tb_row_t;

    // status level in, register index, expected byte
    localparam ffsb_tb_row_t ROWS [16] = '{
        '{7'h00, `FFSB_IDX_FS4, 8'h00}, '{7'h00, `FFSB_IDX_FS5, 8'h00},
        '{7'h00, `FFSB_IDX_ST4, 8'h00}, '{7'h00, `FFSB_IDX_ST5, 8'h00},
        '{7'h00, `FFSB_IDX_CAUSE_A, 8'h00}, '{7'h00, `FFSB_IDX_CAUSE_B, 8'h00},
        '{7'h40, `FFSB_IDX_FS4, 8'h10}, '{7'h20, `FFSB_IDX_FS4, 8'h08},
        '{7'h10, `FFSB_IDX_FS4, 8'h04}, '{7'h08, `FFSB_IDX_FS4, 8'h02},
        '{7'h04, `FFSB_IDX_FS4, 8'h01}, '{7'h02, `FFSB_IDX_FS5, 8'h08},
        '{7'h01, `FFSB_IDX_FS5, 8'h04}, '{7'h7F, `FFSB_IDX_FS4, 8'h1F},
        '{7'h00, `FFSB_IDX_ST4, 8'h1F}, '{7'h00, `FFSB_IDX_ST5, 8'h0C}
    };

    ffsb_bank u_ffsb_bank (
        .clk_i                            (clk_i),
        .rst_i                            (rst_i),
        .ce_i                             (ce_i),
        .wb_adr_i                         (wb_adr_i),
        .wb_dat_i                         (wb_dat_i),
        .wb_sel_i                         (wb_sel_i),
        .wb_we_i                          (wb_we_i),
        .wb_cyc_i                         (wb_cyc_i),
        .wb_stb_i                         (wb_stb_i),
        .wb_dat_o                         (wb_dat_o),
        .wb_ack_o                         (wb_ack_o),
        .faults_i                         (faults_i),
        .status_i                         (status_i),
        .chan_a_secondary_current_input_i (chan_a_secondary_current_input_i),
        .chan_b_secondary_current_input_i (chan_b_secondary_current_input_i),
        .chan_c_off_i                     (chan_c_off_i),
        .chan_c_turn_on_input_i           (chan_c_turn_on_input_i),
        .external_flag_input_i            (external_flag_input_i),
        .chan_restart_i                   (chan_restart_i),
        .flag_sync_output_pin_o           (flag_sync_output_pin_o),
        .chan_shutdown_o                  (chan_shutdown_o),
        .irq_o                            (irq_o)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // entered just after a rising edge; leaves cyc low for one cycle
    task automatic wb_cycle(input logic [15:0] idx, input logic we, input logic [31:0] wd,
                            output logic [31:0] rd);
        rd = 32'h0000_0000;
        wb_adr_i <= {idx, 2'b00};
        wb_we_i  <= we;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        // no local limit: a missing ack is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb_rd(input logic [15:0] idx, output logic [31:0] rd);
        wb_cycle(idx, 1'b0, 32'h0000_0000, rd);
    endtask

    task automatic wb_wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        wb_cycle(idx, 1'b1, wd, dummy);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        wb_rd(idx, v);
        chk_reg(v, exp);
    endtask

    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // run needs well under 1000 cycles; five times that means a hang
    initial begin
        #(5000 * 25);
        fail_count++;
        give_verdict();
    end

    initial begin
        fail_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_adr_i = 18'h0_0000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        faults_i = 12'h000;
        status_i = 7'h00;
        chan_a_secondary_current_input_i = 12'h100;
        chan_b_secondary_current_input_i = 12'h100;
        chan_c_off_i = 1'b0;
        chan_c_turn_on_input_i = 1'b0;
        external_flag_input_i = 1'b0;
        chan_restart_i = 2'b00;
        settle(20);
        rst_i <= 1'b0;
        settle(1);
        for (int i = 0; i < 16; i++) begin
            status_i <= ROWS[i].st;
            settle(4);
            rd_chk(ROWS[i].idx, {24'h00_0000, ROWS[i].exp});
        end
        // read-only, unmapped and write-one-to-clear places
        wb_wr(`FFSB_IDX_FS4, 32'h0000_00FF);
        rd_chk(`FFSB_IDX_FS4, 32'h0000_0000);
        rd_chk(16'h1234, 32'h0000_0000);
        wb_wr(`FFSB_IDX_ST4, 32'h0000_0001);
        rd_chk(`FFSB_IDX_ST4, 32'h0000_001E);
        // channel C off holds past the pulse, interrupt masked then unmasked
        chan_c_off_i <= 1'b1;
        settle(1);
        chan_c_off_i <= 1'b0;
        settle(8);
        rd_chk(`FFSB_IDX_FS4, 32'h0000_0040);
        chk_pin(irq_o, 1'b0);
        wb_wr(`FFSB_IDX_IRQ_MASK, 32'h0000_0004);
        settle(2);
        chk_pin(irq_o, 1'b1);
        chan_c_turn_on_input_i <= 1'b1;
        settle(6);
        chan_c_turn_on_input_i <= 1'b0;
        settle(6);
        rd_chk(`FFSB_IDX_FS4, 32'h0000_0000);
        wb_wr(`FFSB_IDX_IRQ_STAT, 32'h0000_0004);
        settle(2);
        chk_pin(irq_o, 1'b0);
        // low load drives the flag pin; strict less-than
        wb_wr(`FFSB_IDX_LL_THR, 32'h0020_0020);
        chan_a_secondary_current_input_i <= 12'h010;
        settle(6);
        chk_pin(flag_sync_output_pin_o, 1'b1);
        rd_chk(`FFSB_IDX_FS4, 32'h0000_0020);
        chan_a_secondary_current_input_i <= 12'h020;
        settle(6);
        chk_pin(flag_sync_output_pin_o, 1'b0);
        // shutdown cause: first fault only, later ones while down ignored
        wb_wr(`FFSB_IDX_SHUT_EN, 32'h0002_0011);
        faults_i <= 12'h010;
        settle(4);
        chk_reg({30'h0, chan_shutdown_o}, 32'h0000_0001);
        faults_i <= 12'h011;
        settle(4);
        rd_chk(`FFSB_IDX_CAUSE_A, 32'h0000_0005);
        rd_chk(`FFSB_IDX_CAUSE_B, 32'h0000_0000);
        faults_i <= 12'h000;
        chan_restart_i <= 2'b01;
        settle(4);
        chan_restart_i <= 2'b00;
        chk_reg({30'h0, chan_shutdown_o}, 32'h0000_0000);
        faults_i <= 12'h003;
        settle(4);
        rd_chk(`FFSB_IDX_CAUSE_A, 32'h0000_0051);
        rd_chk(`FFSB_IDX_CAUSE_B, 32'h0000_0002);
        rd_chk(`FFSB_IDX_IRQ_STAT, 32'h0000_000B);
        // reverse current on both channels, signed compare, codes 14 and 15
        faults_i <= 12'h000;
        chan_restart_i <= 2'b11;
        settle(4);
        chan_restart_i <= 2'b00;
        wb_wr(`FFSB_IDX_SHUT_EN, 32'h4000_2000);
        wb_wr(`FFSB_IDX_REV_THR, 32'h0000_0008);
        chan_a_secondary_current_input_i <= 12'h005;
        chan_b_secondary_current_input_i <= 12'hFF0;
        settle(6);
        rd_chk(`FFSB_IDX_FS5, 32'h0000_0003);
        rd_chk(`FFSB_IDX_CAUSE_A, 32'h0000_001E);
        rd_chk(`FFSB_IDX_CAUSE_B, 32'h0000_002F);
        // external flag pin as shutdown cause, code 13, channel A only
        chan_a_secondary_current_input_i <= 12'h100;
        chan_b_secondary_current_input_i <= 12'h100;
        chan_restart_i <= 2'b11;
        settle(4);
        chan_restart_i <= 2'b00;
        wb_wr(`FFSB_IDX_SHUT_EN, 32'h0000_1000);
        external_flag_input_i <= 1'b1;
        settle(6);
        rd_chk(`FFSB_IDX_CAUSE_A, 32'h0000_00ED);
        rd_chk(`FFSB_IDX_CAUSE_B, 32'h0000_002F);
        // clock enable low freezes the bank: an off pulse then is not seen
        ce_i <= 1'b0;
        chan_c_off_i <= 1'b1;
        settle(3);
        chan_c_off_i <= 1'b0;
        ce_i <= 1'b1;
        settle(2);
        chk_pin(chan_shutdown_o[0], 1'b1);
        rd_chk(`FFSB_IDX_FS4, 32'h0000_0000);
        // reset in mid-run clears causes, sticky copies and channel state
        external_flag_input_i <= 1'b0;
        rst_i <= 1'b1;
        settle(3);
        rst_i <= 1'b0;
        settle(1);
        chk_reg({30'h0, chan_shutdown_o}, 32'h0000_0000);
        rd_chk(`FFSB_IDX_CAUSE_A, 32'h0000_0000);
        rd_chk(`FFSB_IDX_ST5, 32'h0000_0000);
        rd_chk(`FFSB_IDX_SHUT_EN, 32'h7FFF_7FFF);
        give_verdict();
    end
endmodule // ffsb_bank_tb
